// ### src/hcc_pkg.sv
/*
  Package for the halt code classifier: halt codes, event bit positions,
  carrier structs for the condition inputs and the halt report.
  Assumes a single processor clock domain.
*/
package hcc_pkg;

  localparam int HCC_CODE_W = 6;

  // Halt codes read by console firmware
  localparam logic [5:0] HCC_CODE_NONE = 6'h00;
  localparam logic [5:0] HCC_CODE_MCHK_ACV = 6'h10;
  localparam logic [5:0] HCC_CODE_KSNV_ACV = 6'h11;
  localparam logic [5:0] HCC_CODE_MCHK_MCHK = 6'h12;
  localparam logic [5:0] HCC_CODE_KSNV_MCHK = 6'h13;
  localparam logic [5:0] HCC_CODE_EXC_MODE5 = 6'h19;
  localparam logic [5:0] HCC_CODE_RET_MODE5 = 6'h1D;
  localparam logic [5:0] HCC_CODE_SELFTEST = 6'h3F;
  // Codes for sources whose table code is not available; arbitrary choices
  localparam logic [5:0] HCC_CODE_EXT_HALT = 6'h02;
  localparam logic [5:0] HCC_CODE_HALT_INSN = 6'h06;
  localparam logic [5:0] HCC_CODE_ISNV = 6'h07;
  localparam logic [5:0] HCC_CODE_MCHK_NORM = 6'h08;
  localparam logic [5:0] HCC_CODE_VEC_11 = 6'h09;
  localparam logic [5:0] HCC_CODE_VEC_10 = 6'h0A;
  localparam logic [5:0] HCC_CODE_CHM_IS = 6'h0B;

  // Current-mode and vector low-bit values that are illegal
  localparam logic [2:0] HCC_MODE_FIRST_BAD = 3'h5;
  localparam logic [1:0] HCC_VEC_BAD_11 = 2'h3;
  localparam logic [1:0] HCC_VEC_BAD_10 = 2'h2;

  // Event indicator positions in the system error status word
  localparam int HCC_SES_HALT_BIT = 15;
  localparam int HCC_SES_DCOK_BIT = 14;

  // Conditions sampled each cycle from the processor pipeline
  typedef struct packed {
    logic exc_start;
    logic ret_exec;
    logic [2:0] cur_mode;
    logic in_mchk;
    logic in_ksnv;
    logic in_normal_exc;
    logic mem_fault;
    logic mchk;
    logic halt_insn;
    logic kernel_mode;
    logic istack_invalid;
    logic vec_fetched;
    logic [1:0] vec_low;
    logic chm_exec;
    logic on_istack;
    logic selftest_fail;
  } hcc_cond_s;

  // Halt report seen by firmware
  typedef struct packed {
    logic halted;
    logic [5:0] code;
    logic [15:0] err_status;
  } hcc_report_s;

endpackage : hcc_pkg

// ### src/hcc_sync.sv
/*
  Two flip-flop synchroniser for one backplane level.
  Assumes the input is asynchronous to i_ref_clk.
*/
`timescale 1ns/10ps
module hcc_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;

  // First stage read only by the second
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : hcc_sync

// ### src/hcc_classifier.sv
/*
  Halt code classifier: picks the halt cause, latches a six bit halt code
  and the backplane event indicators for console firmware.
  Assumes condition inputs are synchronous to i_ref_clk; backplane pins are
  asynchronous and pass through hcc_sync. Firmware restart is i_resume.
*/
`timescale 1ns/10ps
module hcc_classifier
  import hcc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire hcc_cond_s i_cond,
  input wire logic i_backplane_halt_request,
  input wire logic i_backplane_dc_ok,
  input wire logic i_backplane_power_ok,
  input wire logic i_resume,
  input wire logic i_clear_status,
  output logic o_halt_pulse,
  output hcc_report_s o_report
);

  // Backplane causes lag their pins by two synchroniser stages; the edge compare against the previous level adds no stage.
  // A cause that arrives while halted is dropped; firmware must read the status flags.
  logic halt_req_s;
  logic dc_ok_s;
  logic power_ok_s;
  logic dc_ok_q;
  logic dc_dropped;
  logic dc_event;
  logic halt_edge_q;
  logic halt_event;
  logic next_hit;
  logic [5:0] next_code;
  logic halted;
  logic [5:0] code;
  logic [15:0] err_status;
  logic nest_cause;
  logic early_cause;
  logic mid_cause;
  logic late_cause;

  // Mode 5,6,7 maps to base, base+1, base+2
  function automatic logic [5:0] mode_code(input logic [5:0] base, input logic [2:0] mode);
    mode_code = base + {4'h0, 2'(mode - HCC_MODE_FIRST_BAD)};
  endfunction : mode_code

  function automatic logic mode_bad(input logic [2:0] mode);
    mode_bad = (mode >= HCC_MODE_FIRST_BAD);
  endfunction : mode_bad

  // Backplane levels come from other boards, so synchronise them
  hcc_sync u_sync_halt (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(i_backplane_halt_request),
    .o_sync(halt_req_s)
  );
  hcc_sync u_sync_dcok (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(i_backplane_dc_ok),
    .o_sync(dc_ok_s)
  );
  hcc_sync u_sync_pok (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(i_backplane_power_ok),
    .o_sync(power_ok_s)
  );

  // Dc-ok drop seen while power-ok holds; a power-ok loss is a power-up, not ours
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dc_ok_q <= 1'b0;
      dc_dropped <= 1'b0;
    end else begin
      dc_ok_q <= dc_ok_s;
      if (!power_ok_s) begin
        dc_dropped <= 1'b0;
      end else if (dc_ok_q && !dc_ok_s) begin
        dc_dropped <= 1'b1;
      end else if (dc_event) begin
        dc_dropped <= 1'b0;
      end
    end
  end

  // Previous halt request level; reset low matches the idle pin, so no false edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      halt_edge_q <= 1'b0;
    end else begin
      halt_edge_q <= halt_req_s;
    end
  end

  assign dc_event = dc_dropped && power_ok_s && dc_ok_s && !dc_ok_q;
  assign halt_event = halt_req_s && !halt_edge_q;

  // Assertion helpers: causes that outrank the later table rows
  assign nest_cause = i_cond.selftest_fail
    || ((i_cond.in_mchk || i_cond.in_ksnv) && (i_cond.mchk || i_cond.mem_fault));
  assign early_cause = nest_cause
    || ((i_cond.exc_start || i_cond.ret_exec) && mode_bad(i_cond.cur_mode));
  assign mid_cause = early_cause || (i_cond.in_normal_exc && i_cond.mchk)
    || (i_cond.exc_start && i_cond.istack_invalid);
  assign late_cause = mid_cause || (i_cond.vec_fetched
    && (i_cond.vec_low == HCC_VEC_BAD_11 || i_cond.vec_low == HCC_VEC_BAD_10));

  // Priority: nested failures first, then mode checks, then plain exceptions
  always_comb begin
    next_hit = 1'b1;
    next_code = HCC_CODE_NONE;
    if (i_cond.selftest_fail) begin
      next_code = HCC_CODE_SELFTEST;
    end else if (i_cond.in_mchk && i_cond.mchk) begin
      next_code = HCC_CODE_MCHK_MCHK;
    end else if (i_cond.in_ksnv && i_cond.mchk) begin
      next_code = HCC_CODE_KSNV_MCHK;
    end else if (i_cond.in_mchk && i_cond.mem_fault) begin
      next_code = HCC_CODE_MCHK_ACV;
    end else if (i_cond.in_ksnv && i_cond.mem_fault) begin
      next_code = HCC_CODE_KSNV_ACV;
    end else if (i_cond.exc_start && mode_bad(i_cond.cur_mode)) begin
      next_code = mode_code(HCC_CODE_EXC_MODE5, i_cond.cur_mode);
    end else if (i_cond.ret_exec && mode_bad(i_cond.cur_mode)) begin
      next_code = mode_code(HCC_CODE_RET_MODE5, i_cond.cur_mode);
    end else if (i_cond.in_normal_exc && i_cond.mchk) begin
      next_code = HCC_CODE_MCHK_NORM;
    end else if (i_cond.exc_start && i_cond.istack_invalid) begin
      next_code = HCC_CODE_ISNV;
    end else if (i_cond.vec_fetched && i_cond.vec_low == HCC_VEC_BAD_11) begin
      next_code = HCC_CODE_VEC_11;
    end else if (i_cond.vec_fetched && i_cond.vec_low == HCC_VEC_BAD_10) begin
      next_code = HCC_CODE_VEC_10;
    end else if (i_cond.chm_exec && i_cond.on_istack) begin
      next_code = HCC_CODE_CHM_IS;
    end else if (i_cond.halt_insn && i_cond.kernel_mode) begin
      next_code = HCC_CODE_HALT_INSN;
    end else if (halt_event || dc_event) begin
      next_code = HCC_CODE_EXT_HALT;
    end else begin
      next_hit = 1'b0;
    end
  end

  // Halt state and code; code is only written on a new halt
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      halted <= 1'b0;
      code <= HCC_CODE_NONE;
    end else if (!halted && next_hit) begin
      halted <= 1'b1;
      code <= next_code;
    end else if (halted && i_resume) begin
      halted <= 1'b0;
    end
  end

  // Event indicators: set wins over a firmware clear in the same cycle
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      err_status <= 16'h0000;
    end else begin
      if (i_clear_status) begin
        err_status <= 16'h0000;
      end
      if (halt_event) begin
        err_status[HCC_SES_HALT_BIT] <= 1'b1;
      end
      if (dc_event) begin
        err_status[HCC_SES_DCOK_BIT] <= 1'b1;
      end
    end
  end

  assign o_halt_pulse = !halted && next_hit;
  assign o_report = '{halted: halted, code: code, err_status: err_status};

  a_code_nest_mchk: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !i_cond.selftest_fail && i_cond.in_mchk && i_cond.mchk)
      |=> (halted && code == HCC_CODE_MCHK_MCHK))
    else $error("nested machine check code wrong");
  a_code_mchk_fault: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !i_cond.selftest_fail && i_cond.in_mchk && !i_cond.mchk && i_cond.mem_fault)
      |=> code == HCC_CODE_MCHK_ACV)
    else $error("fault in machine check code wrong");
  a_code_ksnv_fault: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !i_cond.selftest_fail && !i_cond.in_mchk && i_cond.in_ksnv && !i_cond.mchk
      && i_cond.mem_fault) |=> code == HCC_CODE_KSNV_ACV)
    else $error("fault in stack invalid code wrong");
  a_code_ksnv_mchk: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !i_cond.selftest_fail && !i_cond.in_mchk && i_cond.in_ksnv && i_cond.mchk)
      |=> code == HCC_CODE_KSNV_MCHK)
    else $error("machine check in stack invalid code wrong");
  a_code_selftest: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && i_cond.selftest_fail) |=> (halted && code == HCC_CODE_SELFTEST))
    else $error("self-test halt code wrong");
  a_code_stable_held: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    halted |=> (code == $past(code)))
    else $error("halt code changed while halted");
  a_halt_req_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(halt_req_s) |=> err_status[HCC_SES_HALT_BIT] && (halted || $past(halted)))
    else $error("halt request not flagged");
  a_dcok_halt: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    dc_event |=> (err_status[HCC_SES_DCOK_BIT] && (halted || $past(halted))))
    else $error("dc-ok restart did not halt");
  a_mode_exc: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_halt_pulse && next_code >= HCC_CODE_EXC_MODE5 && next_code < HCC_CODE_RET_MODE5)
      |-> (i_cond.exc_start && mode_bad(i_cond.cur_mode)))
    else $error("mode halt without bad mode");
  a_halt_insn_kernel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && i_cond.halt_insn && i_cond.kernel_mode) |=> halted)
    else $error("kernel halt instruction ignored");

  // Later table rows: the halt itself, then the code where nothing outranks them
  a_mode_ret: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !nest_cause && !i_cond.exc_start && i_cond.ret_exec
      && mode_bad(i_cond.cur_mode)) |=> (halted && code - HCC_CODE_RET_MODE5
      == {3'h0, $past(i_cond.cur_mode) - HCC_MODE_FIRST_BAD}))
    else $error("return mode halt code wrong");
  a_isnv_halt: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && i_cond.exc_start && i_cond.istack_invalid) |=> halted)
    else $error("invalid interrupt stack did not halt");
  a_isnv_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !early_cause && !(i_cond.in_normal_exc && i_cond.mchk) && i_cond.exc_start
      && i_cond.istack_invalid) |=> code == HCC_CODE_ISNV)
    else $error("invalid interrupt stack code wrong");
  a_mchk_norm: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && i_cond.in_normal_exc && i_cond.mchk) |=> halted)
    else $error("machine check in exception did not halt");
  a_mchk_norm_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !early_cause && i_cond.in_normal_exc && i_cond.mchk)
      |=> code == HCC_CODE_MCHK_NORM)
    else $error("machine check in exception code wrong");
  a_vec_bad: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && i_cond.vec_fetched && (i_cond.vec_low == HCC_VEC_BAD_11
      || i_cond.vec_low == HCC_VEC_BAD_10)) |=> halted)
    else $error("bad vector did not halt");
  a_vec11_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !mid_cause && i_cond.vec_fetched && i_cond.vec_low == HCC_VEC_BAD_11)
      |=> code == HCC_CODE_VEC_11)
    else $error("bad vector 11 code wrong");
  a_vec10_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !mid_cause && i_cond.vec_fetched && i_cond.vec_low == HCC_VEC_BAD_10)
      |=> code == HCC_CODE_VEC_10)
    else $error("bad vector 10 code wrong");
  a_chm_istack: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && i_cond.chm_exec && i_cond.on_istack) |=> halted)
    else $error("change mode on interrupt stack did not halt");
  a_chm_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !late_cause && i_cond.chm_exec && i_cond.on_istack)
      |=> code == HCC_CODE_CHM_IS)
    else $error("change mode halt code wrong");
  a_halt_insn_code: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && !late_cause && !(i_cond.chm_exec && i_cond.on_istack) && i_cond.halt_insn
      && i_cond.kernel_mode) |=> code == HCC_CODE_HALT_INSN)
    else $error("halt instruction code wrong");
  a_halt_req_halts: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!halted && halt_event) |=> halted)
    else $error("halt request did not halt");
  a_status_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (halt_event && i_clear_status) |=> err_status[HCC_SES_HALT_BIT])
    else $error("clear beat the halt request flag");
  a_status_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_clear_status && !halt_event && !dc_event) |=> err_status == 16'h0000)
    else $error("status clear ignored");
  a_dcok_arm: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (power_ok_s && dc_ok_q && !dc_ok_s) |=> dc_dropped)
    else $error("dc-ok drop not noted");
  a_pok_disarm: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !power_ok_s |=> !dc_dropped)
    else $error("power loss left a dc-ok drop armed");
  a_resume_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (halted && i_resume) |=> (!halted && code == $past(code)))
    else $error("resume lost the halt code");

  c_nested_mchk: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_halt_pulse && next_code == HCC_CODE_MCHK_MCHK);
  c_ret_mode: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    o_halt_pulse && i_cond.ret_exec && mode_bad(i_cond.cur_mode));
  c_dc_restart: cover property (@(posedge i_ref_clk) disable iff (i_rst) dc_event);
  c_clear_set: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    halt_event && i_clear_status);
  c_resume_rehalt: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    halted && i_resume ##[1:20] o_halt_pulse);

endmodule : hcc_classifier

// ### sim/hcc_fw_model.sv
/*
  Console firmware stand-in: stays in halt for a set number of cycles,
  then pulses resume. Assumes the classifier report on the same clock.
*/
`timescale 1ns/10ps
module hcc_fw_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_halted,
  input wire logic [3:0] i_delay,
  output logic o_resume
);
  logic [3:0] cnt;

  // Slow replies leave room to try causes while halted
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 4'h0;
      o_resume <= 1'b0;
    end else if (i_halted && !o_resume && cnt >= i_delay) begin
      o_resume <= 1'b1; // One-cycle pulse, never outside halt
      cnt <= 4'h0;
    end else begin
      o_resume <= 1'b0;
      cnt <= i_halted ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule : hcc_fw_model

// ### sim/tb_top.sv
/*
  Self-checking bench for the halt code classifier with a firmware model.
  Assumes a 50 MHz clock and active high asynchronous reset.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import hcc_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic bhr = 1'b0;
  logic dcok = 1'b1;
  logic pok = 1'b1;
  logic clr = 1'b0;
  logic resume;
  logic [3:0] fw_delay = 4'h1;
  logic prev_h = 1'b0;
  logic [21:0] e;
  logic [21:0] exp_q[$];
  hcc_cond_s cond = '0;
  hcc_report_s o_report;
  logic o_halt_pulse;
  int checks = 0;
  int n_mismatch = 0;
  logic [5:0] codes [17] = '{HCC_CODE_SELFTEST, HCC_CODE_MCHK_MCHK, HCC_CODE_KSNV_MCHK,
    HCC_CODE_MCHK_ACV, HCC_CODE_KSNV_ACV, 6'h19, 6'h1A, 6'h1B, 6'h1D, 6'h1E, 6'h1F,
    HCC_CODE_MCHK_NORM, HCC_CODE_ISNV, HCC_CODE_VEC_11, HCC_CODE_VEC_10, HCC_CODE_CHM_IS,
    HCC_CODE_HALT_INSN};

  hcc_classifier dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cond(cond),
    .i_backplane_halt_request(bhr), .i_backplane_dc_ok(dcok),
    .i_backplane_power_ok(pok), .i_resume(resume), .i_clear_status(clr),
    .o_halt_pulse(o_halt_pulse), .o_report(o_report));
  hcc_fw_model fw (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_halted(o_report.halted),
    .i_delay(fw_delay), .o_resume(resume));

  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // Bounded wait on the halted level, checked where settled
  task automatic wait_lvl(input logic lvl);
    int n;
    for (n = 0; n < 200 && o_report.halted !== lvl; n++) @(negedge i_ref_clk);
    if (n == 200) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_lvl

  // Table entry k as a one-cycle condition set
  function automatic hcc_cond_s mk(int k);
    hcc_cond_s c;
    c = '0;
    c.selftest_fail = (k == 0);
    c.in_mchk = (k == 1 || k == 3);
    c.in_ksnv = (k == 2 || k == 4);
    c.mchk = (k <= 2 || k == 11);
    c.mem_fault = (k == 3 || k == 4);
    c.exc_start = (k >= 5 && k <= 7) || k == 12;
    c.ret_exec = (k >= 8 && k <= 10);
    c.cur_mode = (k >= 5 && k <= 10) ? 3'h5 + 3'((k - 5) % 3) : 3'h0;
    c.in_normal_exc = (k == 11);
    c.istack_invalid = (k == 12);
    c.vec_fetched = (k == 13 || k == 14);
    c.vec_low = (k == 13) ? 2'h3 : 2'h2;
    c.chm_exec = (k == 15);
    c.on_istack = (k == 15);
    c.halt_insn = (k == 16);
    c.kernel_mode = (k == 16);
    return c;
  endfunction : mk

  task automatic apply(input hcc_cond_s c, input logic pulse);
    @(posedge i_ref_clk) #1 cond = c;
    @(negedge i_ref_clk) `CHK("pulse", pulse, o_halt_pulse)
    @(posedge i_ref_clk) #1 cond = '0;
  endtask : apply

  task automatic fire(input hcc_cond_s c, input logic [21:0] ex);
    wait_lvl(1'b0);
    exp_q.push_back(ex);
    apply(c, 1'b1);
    wait_lvl(1'b1);
  endtask : fire

  // Each halt entry is matched against the oldest expectation
  always @(negedge i_ref_clk) begin
    if (o_report.halted === 1'b1 && prev_h !== 1'b1) begin
      if (exp_q.size() == 0) `CHK("queue", 1'b1, 1'b0)
      else begin
        e = exp_q.pop_front();
        `CHK("report", e, {o_report.code, o_report.err_status})
      end
    end
    prev_h <= o_report.halted;
  end

  initial begin
    hcc_cond_s q;
    void'($urandom(32'h026a));
    repeat (5) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    `CHK("reset", 23'h0, o_report)
    // Every pipeline cause, prompt and slow firmware, benign mode noise between
    for (int k = 0; k < 17; k++) begin
      @(posedge i_ref_clk) #1 cond.cur_mode = 3'($urandom_range(4));
      fw_delay = 4'($urandom_range(3));
      fire(mk(k), {codes[k], 16'h0});
    end
    // Near misses must not halt; leave halt first or the pulse is masked anyway
    wait_lvl(1'b0);
    q = '0;
    q.halt_insn = 1'b1;
    apply(q, 1'b0);
    q = '0;
    q.chm_exec = 1'b1;
    q.vec_fetched = 1'b1;
    q.vec_low = 2'h1;
    q.exc_start = 1'b1;
    q.cur_mode = 3'h4;
    apply(q, 1'b0);
    $display("test causes done");
    // Cause while halted is ignored and the code holds past resume
    fw_delay = 4'hF;
    fire(mk(1), {HCC_CODE_MCHK_MCHK, 16'h0});
    apply(mk(0), 1'b0);
    wait_lvl(1'b0);
    `CHK("held code", HCC_CODE_MCHK_MCHK, o_report.code)
    $display("test hold done");
    // Backplane halt request, then dc-ok restart with power-ok held
    fw_delay = 4'h2;
    @(posedge i_ref_clk) #1 bhr = 1'b1;
    exp_q.push_back({HCC_CODE_EXT_HALT, 16'(1 << HCC_SES_HALT_BIT)});
    // Firmware clear lands on the event edge: the flag must still be set
    @(posedge i_ref_clk);
    @(posedge i_ref_clk) #1 clr = 1'b1;
    @(posedge i_ref_clk) #1 clr = 1'b0;
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    @(posedge i_ref_clk) #1 bhr = 1'b0;
    clr = 1'b1;
    @(posedge i_ref_clk) #1 clr = 1'b0;
    @(negedge i_ref_clk) `CHK("status", 16'h0, o_report.err_status)
    @(posedge i_ref_clk) #1 dcok = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #1 dcok = 1'b1;
    exp_q.push_back({HCC_CODE_EXT_HALT, 16'(1 << HCC_SES_DCOK_BIT)});
    wait_lvl(1'b1);
    @(negedge i_ref_clk) `CHK("queue empty", 0, exp_q.size())
    // Power-ok and dc-ok cycling together is a power-up: no halt
    wait_lvl(1'b0);
    @(posedge i_ref_clk) #1 pok = 1'b0;
    dcok = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #1 pok = 1'b1;
    dcok = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    `CHK("power-up halt", 1'b0, o_report.halted)
    $display("test backplane done");
    report_and_stop();
  end
endmodule : tb_top
